//--- ofd_map.vh
`ifndef OFD_MAP_VH
`define OFD_MAP_VH
// flag bit positions
`define OFD_FLAG_S      7
`define OFD_FLAG_Z      6
`define OFD_FLAG_H      4
`define OFD_FLAG_PV     2
`define OFD_FLAG_N      1
`define OFD_FLAG_C      0
// register index inside the byte file
`define OFD_REG_ACC     3'h7
`define OFD_REG_MEM     3'h6
// prefixes and opcode layout
`define OFD_PFX_X       8'hdd
`define OFD_PFX_Y       8'hfd
`define OFD_GRP_REG     2'h2
`define OFD_GRP_IMM     2'h3
`define OFD_LOW_IMM     3'h6
`define OFD_OP_ADD      3'h0
`define OFD_OP_ADC      3'h1
// pair field codes
`define OFD_PAIR_FIRST  2'h0
`define OFD_PAIR_SECOND 2'h1
`define OFD_PAIR_THIRD  2'h2
`define OFD_PAIR_STACK  2'h3
// pair field kinds
`define OFD_KIND_PTR    2'h0
`define OFD_KIND_IX     2'h1
`define OFD_KIND_IY     2'h2
// state counts
`define OFD_ST_REG      4'h4
`define OFD_ST_MEM      4'h6
`define OFD_ST_IDX      4'he
// reset values
`define OFD_RST_BYTE    8'h00
`define OFD_RST_WORD    16'h0000
`endif

//--- ofd_field_dec.v
`timescale 1ns/1ns
`default_nettype none
`include "ofd_map.vh"
module ofd_field_dec (
  input  wire [2:0]  reg_field,    // single-register field
  input  wire [1:0]  pair_field,   // register-pair field
  input  wire [1:0]  pair_kind,    // field type of pair field
  input  wire        half_sel,     // 1 high half, 0 low half
  input  wire [2:0]  bit_field,    // bit number field
  input  wire [2:0]  cond_field,   // branch condition field
  input  wire [2:0]  rst_field,    // restart field
  input  wire [7:0]  flags,        // current flags
  output reg  [2:0]  reg_index,    // byte register index
  output wire        reg_is_mem,   // field selects memory byte
  output reg  [2:0]  pair_index,   // 0..1 pairs,3 ptr,4 ix,5 iy,6 sp
  output wire        half_high,    // upper half selected
  output wire [7:0]  bit_mask,     // one-hot bit mask
  output reg         cond_true,    // condition met
  output wire [7:0]  rst_vector    // restart address
);
  //////////////////////////////////////////////////////////////////////
  always @* begin
    reg_index = reg_field;
  end
  assign reg_is_mem = (reg_field == `OFD_REG_MEM);
  //////////////////////////////////////////////////////////////////////
  always @* begin
    case (pair_field)
      `OFD_PAIR_FIRST:  pair_index = 3'h0;
      `OFD_PAIR_SECOND: pair_index = 3'h1;
      `OFD_PAIR_THIRD:
        pair_index = (pair_kind == `OFD_KIND_IX) ? 3'h4 :
                     (pair_kind == `OFD_KIND_IY) ? 3'h5 : 3'h3;
      default:          pair_index = 3'h6;
    endcase
  end
  assign half_high  = half_sel;
  assign bit_mask   = 8'h01 << bit_field;
  assign rst_vector = {2'h0, rst_field, 3'h0};
  //////////////////////////////////////////////////////////////////////
  always @* begin
    case (cond_field)
      3'h0:    cond_true = ~flags[`OFD_FLAG_Z];
      3'h1:    cond_true = flags[`OFD_FLAG_Z];
      3'h2:    cond_true = ~flags[`OFD_FLAG_C];
      3'h3:    cond_true = flags[`OFD_FLAG_C];
      3'h4:    cond_true = ~flags[`OFD_FLAG_PV];
      3'h5:    cond_true = flags[`OFD_FLAG_PV];
      3'h6:    cond_true = ~flags[`OFD_FLAG_S];
      default: cond_true = flags[`OFD_FLAG_S];
    endcase
  end
endmodule // ofd_field_dec
`default_nettype wire

//--- ofd_adder.v
`timescale 1ns/1ns
`default_nettype none
`include "ofd_map.vh"
module ofd_adder (
  input  wire [7:0] acc,       // accumulator
  input  wire [7:0] operand,   // source byte
  input  wire       use_carry, // add-with-carry
  input  wire [7:0] flags_in,  // current flags
  output wire [7:0] sum,       // result
  output wire [7:0] flags_out  // new flags
);
  wire       cin;
  wire [4:0] low;
  wire [8:0] full;
  wire [7:0] f;
  assign cin  = use_carry & flags_in[`OFD_FLAG_C];
  assign low  = {1'b0, acc[3:0]} + {1'b0, operand[3:0]} + {4'h0, cin};
  assign full = {1'b0, acc} + {1'b0, operand} + {8'h00, cin};
  assign sum  = full[7:0];
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_flag
      if (i == `OFD_FLAG_S) begin : g_s
        assign f[i] = full[7];
      end else if (i == `OFD_FLAG_Z) begin : g_z
        assign f[i] = (full[7:0] == 8'h00);
      end else if (i == `OFD_FLAG_H) begin : g_h
        assign f[i] = low[4];
      end else if (i == `OFD_FLAG_PV) begin : g_v
        // signed overflow, not parity, for additions
        assign f[i] = (acc[7] == operand[7]) & (full[7] != acc[7]);
      end else if (i == `OFD_FLAG_N) begin : g_n
        assign f[i] = 1'b0;
      end else if (i == `OFD_FLAG_C) begin : g_c
        assign f[i] = full[8];
      end else begin : g_keep
        assign f[i] = flags_in[i];
      end
    end
  endgenerate
  assign flags_out = f;
endmodule // ofd_adder
`default_nettype wire

//--- ofd_decode_add.v
`timescale 1ns/1ns
`default_nettype none
`include "ofd_map.vh"
module ofd_decode_add (
  input  wire        clk,          // 20 MHz core clock
  input  wire        rst_n,        // async reset, active low
  input  wire        byte_valid,   // fetch byte offered
  input  wire [7:0]  byte_data,    // opcode/operand byte
  output wire        byte_ready,   // byte taken this cycle
  output reg         mem_rd,       // memory operand read request
  output reg  [15:0] mem_addr,     // memory operand address
  input  wire        mem_valid,    // memory data returned
  input  wire [7:0]  mem_data,     // memory data
  input  wire        reg_wr,       // external register load strobe
  input  wire [2:0]  reg_wr_sel,   // register loaded (g code)
  input  wire [7:0]  reg_wr_data,  // value loaded
  input  wire        pair_wr,      // external pair load strobe
  input  wire [2:0]  pair_wr_sel,  // pair index loaded
  input  wire [15:0] pair_wr_data, // value loaded
  input  wire [1:0]  pair_field,   // pair field to decode
  input  wire [1:0]  pair_kind,    // 0 pointer,1 x,2 y type
  input  wire        half_sel,     // high half qualifier
  input  wire [2:0]  bit_field,    // bit field to decode
  input  wire [2:0]  cond_field,   // condition field to decode
  input  wire [2:0]  rst_field,    // restart field to decode
  output wire [7:0]  pair_half,    // selected half of pair
  output wire [7:0]  bit_mask,     // decoded bit mask
  output wire        cond_true,    // condition met
  output wire [7:0]  rst_vector,   // restart vector
  output reg  [7:0]  acc,          // accumulator
  output reg  [7:0]  flags,        // flag register
  output reg         done,         // instruction complete pulse
  output reg  [3:0]  state_count,  // states of finished instruction
  output reg         illegal       // unsupported opcode pulse
);
  //////////////////////////////////////////////////////////////////////
  localparam [6:0] S_OP    = 7'h01;
  localparam [6:0] S_OP2   = 7'h02;
  localparam [6:0] S_IMM   = 7'h04;
  localparam [6:0] S_DISP  = 7'h08;
  localparam [6:0] S_MREQ  = 7'h10;
  localparam [6:0] S_MWAIT = 7'h20;
  localparam [6:0] S_EXEC  = 7'h40;

  reg  [6:0]  state;
  reg  [6:0]  next_state;
  reg  [7:0]  gr [0:5];
  reg  [15:0] wr [0:3];   // pointer, x, y, stack
  reg  [1:0]  pfx;        // 0 none, 1 x, 2 y
  reg         carry_op;
  reg  [7:0]  operand;
  reg  [3:0]  states;

  wire [2:0] reg_index;
  wire       reg_is_mem;
  wire [2:0] pair_index;
  wire       half_high;
  wire [7:0] sum;
  wire [7:0] flags_new;
  wire       opc_add;
  wire       opc_adc;
  wire [15:0] base;
  wire [15:0] disp_ext;
  reg  [15:0] pair_val;
  reg  [7:0]  reg_val;
  wire        is_prefix;
  wire        is_add_grp;
  wire        is_imm_form;
  wire        is_reg_form;
  wire        is_mem_form;
  wire        in_opcode;
  wire        bad_op;

  //////////////////////////////////////////////////////////////////////
  ofd_field_dec u_fd (
    .reg_field  (byte_data[2:0]),
    .pair_field (pair_field),
    .pair_kind  (pair_kind),
    .half_sel   (half_sel),
    .bit_field  (bit_field),
    .cond_field (cond_field),
    .rst_field  (rst_field),
    .flags      (flags),
    .reg_index  (reg_index),
    .reg_is_mem (reg_is_mem),
    .pair_index (pair_index),
    .half_high  (half_high),
    .bit_mask   (bit_mask),
    .cond_true  (cond_true),
    .rst_vector (rst_vector)
  );

  ofd_adder u_add (
    .acc       (acc),
    .operand   (operand),
    .use_carry (carry_op),
    .flags_in  (flags),
    .sum       (sum),
    .flags_out (flags_new)
  );

  //////////////////////////////////////////////////////////////////////
  always @* begin
    case (pair_index)
      3'h0:    pair_val = {gr[0], gr[1]};
      3'h1:    pair_val = {gr[2], gr[3]};
      3'h3:    pair_val = wr[0];
      3'h4:    pair_val = wr[1];
      3'h5:    pair_val = wr[2];
      default: pair_val = wr[3];
    endcase
  end
  assign pair_half = half_high ? pair_val[15:8] : pair_val[7:0];

  always @* begin
    if (reg_index == `OFD_REG_ACC)
      reg_val = acc;
    else if (reg_index == `OFD_REG_MEM)
      reg_val = `OFD_RST_BYTE;
    else
      reg_val = gr[reg_index];
  end

  // add group: 10 00c sss or 11 00c 110
  assign opc_add = (byte_data[5:3] == `OFD_OP_ADD);
  assign opc_adc = (byte_data[5:3] == `OFD_OP_ADC);
  assign base     = (pfx == 2'h1) ? wr[1] : (pfx == 2'h2) ? wr[2] : wr[0];
  assign disp_ext = {{8{byte_data[7]}}, byte_data};

  // opcode classes; the middle field picks plain add or add-with-carry
  assign is_prefix   = (byte_data == `OFD_PFX_X) | (byte_data == `OFD_PFX_Y);
  assign is_add_grp  = opc_add | opc_adc;
  assign is_imm_form = (byte_data[7:6] == `OFD_GRP_IMM) & (byte_data[2:0] == `OFD_LOW_IMM);
  assign is_mem_form = (byte_data[7:6] == `OFD_GRP_REG) & reg_is_mem;
  assign is_reg_form = (byte_data[7:6] == `OFD_GRP_REG) & ~reg_is_mem;
  assign in_opcode   = (state == S_OP) | (state == S_OP2);
  // anything the sequencer cannot run falls back to opcode fetch
  assign bad_op      = in_opcode & byte_valid & (next_state == S_OP);

  assign byte_ready = (state == S_OP) | (state == S_OP2) |
                      (state == S_IMM) | (state == S_DISP);

  //////////////////////////////////////////////////////////////////////
  always @* begin
    next_state = state;
    case (state)
      S_OP, S_OP2: begin
        if (byte_valid) begin
          if (state == S_OP && is_prefix)
            next_state = S_OP2;
          else if (!is_add_grp)
            next_state = S_OP;
          else if (state == S_OP && is_imm_form)
            next_state = S_IMM;
          else if (is_mem_form)
            next_state = (state == S_OP2) ? S_DISP : S_MREQ;
          else if (state == S_OP && is_reg_form)
            next_state = S_EXEC;
          else
            next_state = S_OP;
        end
      end
      S_IMM:   next_state = byte_valid ? S_EXEC : S_IMM;
      S_DISP:  next_state = byte_valid ? S_MREQ : S_DISP;
      S_MREQ:  next_state = S_MWAIT;
      S_MWAIT: next_state = mem_valid ? S_EXEC : S_MWAIT;
      S_EXEC:  next_state = S_OP;
      default: next_state = S_OP;
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // register file: one bank per entry; accumulator and flags stay ours
  genvar n;
  generate
    for (n = 0; n < 6; n = n + 1) begin : g_gr
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n)
          gr[n] <= `OFD_RST_BYTE;
        else if (reg_wr && {29'h0, reg_wr_sel} == n)
          gr[n] <= reg_wr_data;
      end
    end
    // pair codes 3..6; first and second pairs live in the byte banks
    for (n = 0; n < 4; n = n + 1) begin : g_wr
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n)
          wr[n] <= `OFD_RST_WORD;
        else if (pair_wr && {29'h0, pair_wr_sel} == n + 3)
          wr[n] <= pair_wr_data;
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////
  always @(posedge clk or negedge rst_n) begin : p_seq
    if (!rst_n) begin
      state    <= S_OP;
      pfx      <= 2'h0;
      carry_op <= 1'b0;
      operand  <= `OFD_RST_BYTE;
      states   <= 4'h0;
      mem_rd   <= 1'b0;
      mem_addr <= `OFD_RST_WORD;
    end else begin
      state  <= next_state;
      mem_rd <= 1'b0;
      case (state)
        S_OP, S_OP2: begin
          if (byte_valid) begin
            carry_op <= opc_adc;
            if (next_state == S_OP2) begin
              pfx <= (byte_data == `OFD_PFX_X) ? 2'h1 : 2'h2;
            end else if (next_state == S_EXEC) begin
              operand <= reg_val;
              states  <= `OFD_ST_REG;
            end else if (next_state == S_IMM) begin
              states  <= `OFD_ST_MEM;
            end else if (next_state == S_MREQ) begin
              mem_addr <= wr[0];
              states   <= `OFD_ST_MEM;
            end else if (next_state == S_DISP) begin
              states   <= `OFD_ST_IDX;
            end else begin
              // a dropped opcode also drops any prefix ahead of it
              pfx <= 2'h0;
            end
          end
        end
        S_IMM: begin
          if (byte_valid)
            operand <= byte_data;
        end
        S_DISP: begin
          if (byte_valid)
            mem_addr <= base + disp_ext;
        end
        S_MREQ: begin
          mem_rd <= 1'b1;
        end
        S_MWAIT: begin
          if (mem_valid)
            operand <= mem_data;
        end
        S_EXEC: begin
          pfx <= 2'h0;
        end
        default: begin
          pfx <= 2'h0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // accumulator and flags move only at the end of an add
  always @(posedge clk or negedge rst_n) begin : p_acc
    if (!rst_n) begin
      acc   <= `OFD_RST_BYTE;
      flags <= `OFD_RST_BYTE;
    end else if (state == S_EXEC) begin
      acc   <= sum;
      flags <= flags_new;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // status pulses; state_count reports the documented figure, not cycles
  always @(posedge clk or negedge rst_n) begin : p_report
    if (!rst_n) begin
      done        <= 1'b0;
      state_count <= 4'h0;
      illegal     <= 1'b0;
    end else begin
      done    <= (state == S_EXEC);
      illegal <= bad_op;
      if (state == S_EXEC)
        state_count <= states;
    end
  end
endmodule // ofd_decode_add
`default_nettype wire

//--- ofd_decode_add_chk.sv
`timescale 1ns/1ns
`default_nettype none
module ofd_decode_add_chk (
  input wire logic       clk,         // clock
  input wire logic       rst_n,       // reset, low
  input wire logic       byte_valid,  // byte offered
  input wire logic [7:0] byte_data,   // byte
  input wire logic       byte_ready,  // byte taken
  input wire logic       mem_rd,      // operand read
  input wire logic [2:0] bit_field,   // bit field
  input wire logic [2:0] cond_field,  // condition
  input wire logic [2:0] rst_field,   // restart field
  input wire logic [7:0] bit_mask,    // mask
  input wire logic       cond_true,   // condition met
  input wire logic [7:0] rst_vector,  // vector
  input wire logic [7:0] acc,         // accumulator
  input wire logic [7:0] flags,       // flags
  input wire logic       done,        // finished
  input wire logic [3:0] state_count  // states
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  // operand bytes can look like opcodes, so track the fetch position
  logic [1:0] pos;
  wire        take = byte_valid && byte_ready;
  wire        col  = byte_data[5:4] == 2'h0;
  wire        low6 = byte_data[2:0] == 3'h6;
  wire        grp  = pos == 2'h0 ? byte_data[7:6] == 2'h3 : byte_data[7:6] == 2'h2;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) pos <= 2'h0;
    else if (take) begin
      if (pos == 2'h0 && (byte_data == 8'hdd || byte_data == 8'hfd)) pos <= 2'h1;
      else if (pos != 2'h2 && grp && col && low6) pos <= 2'h2;
      else pos <= 2'h0;
    end
  end
  function automatic logic cond_of(input logic [2:0] f, input logic [7:0] fl);
    logic x;
    x = f[2:1] == 2'h0 ? fl[6] : f[2:1] == 2'h1 ? fl[0] : f[2:1] == 2'h2 ? fl[2] : fl[7];
    return f[0] ? x : !x;
  endfunction
  sequence s_reg_op;
    take && pos == 2'h0 && byte_data[7:6] == 2'h2 && col && !low6;
  endsequence
  sequence s_imm_op;
    take && pos == 2'h0 && byte_data[7:6] == 2'h3 && col && low6;
  endsequence
  sequence s_idx_op;
    take && pos == 2'h1 && byte_data[7:6] == 2'h2 && col && low6;
  endsequence
  sequence s_done(logic [3:0] st);
    done && state_count == st;
  endsequence
  property p_reg_done; s_reg_op |=> !done ##1 s_done(4'h4); endproperty
  a_reg_done: assert property (p_reg_done)
    else $error("register add timing");
  property p_imm_done; s_imm_op |-> ##[2:4] s_done(4'h6); endproperty
  a_imm_done: assert property (p_imm_done)
    else $error("immediate add timing");
  property p_idx_done; s_idx_op |-> ##[4:20] s_done(4'he); endproperty
  a_idx_done: assert property (p_idx_done)
    else $error("indexed add timing");
  property p_mem_rd; mem_rd |-> !byte_ready ##1 !mem_rd; endproperty
  a_mem_rd: assert property (p_mem_rd)
    else $error("memory read pulse");
  property p_sub; done |-> !flags[1]; endproperty
  a_sub: assert property (p_sub)
    else $error("subtract flag set");
  property p_res; done |-> flags[7] == acc[7] && flags[6] == (acc == 8'h00); endproperty
  a_res: assert property (p_res)
    else $error("sign or zero flag");
  property p_mask; $onehot(bit_mask) && bit_mask[bit_field]; endproperty
  a_mask: assert property (p_mask)
    else $error("bit mask");
  property p_rst; rst_vector == {5'h00, rst_field} * 8'h08; endproperty
  a_rst: assert property (p_rst)
    else $error("restart vector");
  property p_cond; cond_true == cond_of(cond_field, flags); endproperty
  a_cond: assert property (p_cond)
    else $error("condition");
endmodule // ofd_decode_add_chk
bind ofd_decode_add ofd_decode_add_chk u_chk (.clk(clk), .rst_n(rst_n),
  .byte_valid(byte_valid), .byte_data(byte_data), .byte_ready(byte_ready),
  .mem_rd(mem_rd), .bit_field(bit_field), .cond_field(cond_field),
  .rst_field(rst_field), .bit_mask(bit_mask), .cond_true(cond_true),
  .rst_vector(rst_vector), .acc(acc), .flags(flags), .done(done),
  .state_count(state_count));
`default_nettype wire

//--- ofd_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module ofd_mem_model (
  input  wire logic        clk,       // clock
  input  wire logic        rst_n,     // reset, low
  input  wire logic        mem_rd,    // read request
  input  wire logic [15:0] mem_addr,  // address
  input  wire logic [2:0]  lat,       // extra wait cycles
  output var  logic        mem_valid, // data returned
  output var  logic [7:0]  mem_data   // data
);
  logic [2:0]  cnt;
  logic        busy;
  logic [15:0] a;
  ////////////////////////////////////////
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      cnt <= 3'h0;
      a <= 16'h0000;
      mem_valid <= 1'b0;
      mem_data <= 8'h00;
    end else begin
      mem_valid <= 1'b0;
      // mem_data inverted every cycle outside the reply cycle
      mem_data <= ~mem_data;
      if (mem_rd) begin
        busy <= 1'b1;
        cnt <= lat;
        a <= mem_addr;
      end else if (busy && cnt == 3'h0) begin
        busy <= 1'b0;
        mem_valid <= 1'b1;
        mem_data <= a[7:0] ^ a[15:8];
      end else if (busy) cnt <= cnt - 3'h1;
    end
  end
endmodule // ofd_mem_model
`default_nettype wire

//--- ofd_decode_add_bench.sv
`timescale 1ns/1ns
`default_nettype none
module ofd_decode_add_bench;
  logic        clk, rst_n, byte_valid, mem_valid, reg_wr, pair_wr, half_sel, adc;
  logic        byte_ready, mem_rd, cond_true, done, illegal;
  logic [7:0]  byte_data, mem_data, reg_wr_data, pair_half, bit_mask, rst_vector;
  logic [7:0]  acc, flags, ea, ef, v;
  logic [2:0]  reg_wr_sel, pair_wr_sel, bit_field, cond_field, rst_field, lat, g;
  logic [1:0]  pair_field, pair_kind;
  logic [3:0]  state_count;
  logic [15:0] mem_addr, pair_wr_data, last_addr, w;
  logic [7:0]  r [0:5];
  logic [15:0] pr [3:6];
  integer      errors, total_checks, seed, cyc, i, j, k;
  ofd_decode_add u_ofd_decode_add (.clk(clk), .rst_n(rst_n), .byte_valid(byte_valid),
    .byte_data(byte_data), .byte_ready(byte_ready), .mem_rd(mem_rd), .mem_addr(mem_addr),
    .mem_valid(mem_valid), .mem_data(mem_data), .reg_wr(reg_wr), .reg_wr_sel(reg_wr_sel),
    .reg_wr_data(reg_wr_data), .pair_wr(pair_wr), .pair_wr_sel(pair_wr_sel),
    .pair_wr_data(pair_wr_data), .pair_field(pair_field), .pair_kind(pair_kind),
    .half_sel(half_sel), .bit_field(bit_field), .cond_field(cond_field),
    .rst_field(rst_field), .pair_half(pair_half), .bit_mask(bit_mask),
    .cond_true(cond_true), .rst_vector(rst_vector), .acc(acc), .flags(flags),
    .done(done), .state_count(state_count), .illegal(illegal));
  ofd_mem_model u_ofd_mem_model (.clk(clk), .rst_n(rst_n), .mem_rd(mem_rd),
    .mem_addr(mem_addr), .lat(lat), .mem_valid(mem_valid), .mem_data(mem_data));
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (mem_rd) last_addr <= mem_addr;
    if (cyc == 20000) begin
      errors = errors + 1;
      $display("Error %0t run too long", $time);
      end_of_test;
    end
  end
  task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("Error %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // flags word with undefined bits 5 and 3 left zero
  function logic [15:0] add_exp(input logic [7:0] a, b, input logic cin);
    logic [8:0] s;
    logic [4:0] h;
    s = a + b + cin;
    h = a[3:0] + b[3:0] + cin;
    return {s[7:0], s[7], s[7:0] == 8'h00, 1'b0, h[4], 1'b0,
            a[7] == b[7] && s[7] != a[7], 1'b0, s[8]};
  endfunction
  function logic cond_exp(input logic [2:0] f);
    logic x;
    x = f[2:1] == 2'h0 ? ef[6] : f[2:1] == 2'h1 ? ef[0] : f[2:1] == 2'h2 ? ef[2] : ef[7];
    return f[0] ? x : !x;
  endfunction
  // holds valid up across bytes; caller drops it after the last one
  task send(input logic [7:0] b);
    byte_valid = 1'b1;
    byte_data = b;
    for (j = 0; j < 50 && byte_ready !== 1'b1; j = j + 1) @(negedge clk);
    @(negedge clk);
  endtask
  task load_all;
    reg_wr = 1'b1;
    for (i = 0; i < 6; i = i + 1) begin
      r[i] = $random(seed);
      reg_wr_sel = i[2:0];
      reg_wr_data = r[i];
      @(negedge clk);
    end
    reg_wr = 1'b0;
    pair_wr = 1'b1;
    for (i = 3; i < 7; i = i + 1) begin
      pr[i] = $random(seed);
      pair_wr_sel = i[2:0];
      pair_wr_data = pr[i];
      @(negedge clk);
    end
    pair_wr = 1'b0;
  endtask
  // form: 0 register, 1 pointer memory, 2 immediate, 3 x indexed, 4 y indexed
  task do_add(input int form);
    logic [7:0]  op;
    logic [15:0] ad, res;
    ad = form == 1 ? pr[3] : (form == 3 ? pr[4] : pr[5]) + {{8{v[7]}}, v};
    op = {form == 2 ? 2'h3 : 2'h2, 2'h0, adc, form == 0 ? g : 3'h6};
    res = add_exp(ea, form == 0 ? (g == 3'h7 ? ea : r[g]) : form == 2 ? v : ad[7:0] ^ ad[15:8],
                  adc & ef[0]);
    if (form > 2) send(form == 3 ? 8'hdd : 8'hfd);
    send(op);
    if (form > 1) send(v);
    byte_valid = 1'b0;
    for (j = 0; j < 40 && done !== 1'b1; j = j + 1) @(negedge clk);
    chk(acc, res[15:8], "acc");
    chk(flags & 8'hd7, res[7:0], "flags");
    chk(state_count, form == 0 ? 4'h4 : form < 3 ? 4'h6 : 4'he, "states");
    if (form == 1 || form > 2) chk(last_addr, ad, "addr");
    ea = res[15:8];
    ef = res[7:0];
    @(negedge clk);
  endtask
  task fields;
    for (i = 0; i < 24; i = i + 1) begin
      bit_field = i[2:0];
      rst_field = i[2:0];
      cond_field = i[2:0];
      pair_field = i[1:0];
      pair_kind = i[4:3];
      half_sel = i[2];
      w = i[1:0] == 2'h0 ? {r[0], r[1]} : i[1:0] == 2'h1 ? {r[2], r[3]} :
          i[1:0] == 2'h2 ? pr[3 + i[4:3]] : pr[6];
      #1;
      chk(bit_mask, 8'h01 << i[2:0], "mask");
      chk(rst_vector, {2'h0, i[2:0], 3'h0}, "vector");
      chk(cond_true, cond_exp(i[2:0]), "cond");
      chk(pair_half, half_sel ? w[15:8] : w[7:0], "pair");
      @(negedge clk);
    end
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    {errors, total_checks, cyc} = 0;
    seed = 94937;
    {rst_n, byte_valid, reg_wr, pair_wr, half_sel, adc, byte_data, reg_wr_data} = 0;
    {reg_wr_sel, pair_wr_sel, bit_field, cond_field, rst_field, lat, g} = 0;
    {pair_field, pair_kind, pair_wr_data, v, ea, ef} = 0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    load_all;
    // every register code except memory (6), plain and with carry
    for (k = 0; k < 16; k = k + 1) begin
      g = k[2:0];
      adc = k[3];
      if (g != 3'h6) do_add(0);
    end
    // memory and immediate forms at displacement extremes, slow and prompt memory
    for (k = 0; k < 16; k = k + 1) begin
      adc = k[3];
      v = k[2] ? 8'h80 : 8'h7f;
      lat = k[2:0];
      do_add(1 + k % 4);
    end
    fields;
    for (k = 0; k < 40; k = k + 1) begin
      if (k % 10 == 0) load_all;
      g = $random(seed);
      if (g == 3'h6) g = 3'h7;
      {adc, lat, v} = $random(seed);
      do_add({$random(seed)} % 5);
      fields;
    end
    // non-add opcode, then a prefix ahead of a register form: both dropped
    for (k = 0; k < 2; k = k + 1) begin
      if (k == 1) send(8'hdd);
      send(k == 0 ? 8'h00 : 8'h80);
      byte_valid = 1'b0;
      for (j = 0; j < 5 && illegal !== 1'b1; j = j + 1) @(negedge clk);
      chk(illegal, 1'b1, "illegal");
      @(negedge clk);
      chk(acc, ea, "acc kept");
    end
    end_of_test;
  end
endmodule // ofd_decode_add_bench
`default_nettype wire
